//--- include/mfcc_pkg.sv
// constants and types shared by the frame check codes block
package mfcc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ     = 125_000_000;
	localparam int SILENT_MS  = 10;
	// least time, so round up to whole cycles
	localparam int SILENT_CYC = (SILENT_MS * CLK_HZ + 999) / 1000;
	localparam int SIL_W      = 21;

	// ------------------------------------------------------------
	// check codes
	// ------------------------------------------------------------
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [15:0] CRC_POLY  = 16'hA001;
	localparam logic [2:0]  BIT_LAST  = 3'h7;   // eighth bit step
	localparam logic [7:0]  LRC_ZERO  = 8'h00;

	// ------------------------------------------------------------
	// characters and function codes
	// ------------------------------------------------------------
	localparam logic [7:0] CH_START = 8'h3A;   // frame_start_char
	localparam logic [7:0] CH_CR    = 8'h0D;
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_0     = 8'h30;
	localparam logic [7:0] CH_9     = 8'h39;
	localparam logic [7:0] CH_A     = 8'h41;
	localparam logic [7:0] CH_F     = 8'h46;
	localparam logic [7:0] FN_WR_ONE   = 8'h06;
	localparam logic [7:0] FN_WR_MULTI = 8'h10;
	localparam logic [15:0] MAX_WORDS  = 16'h000A;

	// ------------------------------------------------------------
	// frame layout and storage
	// ------------------------------------------------------------
	localparam int POS_STATION = 0;
	localparam int POS_FUNC    = 1;
	localparam int POS_ADDR_HI = 2;
	localparam int POS_ADDR_LO = 3;
	localparam int POS_CNT_HI  = 4;
	localparam int POS_CNT_LO  = 5;
	localparam int POS_BCNT    = 6;
	localparam int POS_DATA    = 7;
	localparam int BUF_BYTES   = 32;
	localparam int IDX_W       = 6;
	localparam int FIFO_DEPTH  = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RECV  = 3'b001,
		ST_STEP  = 3'b010,
		ST_LF    = 3'b011,
		ST_CHECK = 3'b100,
		ST_DRAIN = 3'b101
	} mfcc_state_e;

	typedef enum logic {
		MODE_ASCII = 1'b0,
		MODE_RTU   = 1'b1
	} mfcc_mode_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} mfcc_wr_s;

	typedef struct packed {
		logic        ok;
		logic        bad;
		logic [7:0]  func;
		logic [15:0] check;
	} mfcc_stat_s;
endpackage

//--- hw/mfcc_fifo.sv
// small word fifo between the frame checker and the parameter store
`timescale 1ns/1ns
module mfcc_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input  wire logic         core_clk,   // system clock
	input  wire logic         rstn,       // async reset, active low
	input  wire logic         in_valid,   // write word offered
	input  wire logic [W-1:0] in_data,    // write word
	output logic              in_ready,   // room for a word
	output logic              out_valid,  // word available
	output logic [W-1:0]      out_data,   // oldest word
	input  wire logic         out_ready   // consumer takes word
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} mfcc_fifo_s;

	mfcc_fifo_s s;
	mfcc_fifo_s next_s;
	logic       push;
	logic       pop;

	// full and empty come from the count, never from pointer guesses
	assign in_ready  = (s.cnt != (AW+1)'(D));
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + AW'(1);
		end
		if (pop)
			next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + AW'(1);
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end
endmodule // mfcc_fifo

//--- hw/mfcc_core.sv
// frame delimiting, check code verification and write word framing
`timescale 1ns/1ns
// Overview of operation
// - ascii uses lrc, rtu uses 16-bit crc
// - lrc is two's complement of byte sum
// - lrc covers binary bytes, not delimiters
// - crc accumulator starts at all ones
// - each byte xored into crc low byte
// - shift right, xor polynomial if lsb one
// - exactly eight bit steps per byte
// - fold every byte before check field
// - crc low byte sent before high byte
// - rtu frames delimited by 10 ms silence
// - ascii colon start, cr lf end, hex
// - at most ten words per access
module mfcc_core import mfcc_pkg::*; #(
	parameter int SILENT_CYC_P = mfcc_pkg::SILENT_CYC,
	parameter int DEPTH        = mfcc_pkg::FIFO_DEPTH
) (
	input  wire logic                core_clk,    // system clock
	input  wire logic                rstn,        // async reset, low
	input  mfcc_pkg::mfcc_mode_e     mode,        // ascii or rtu
	input  wire logic [7:0]          my_station,  // own station address
	input  wire logic                rx_valid,    // byte from uart
	input  wire logic [7:0]          rx_byte,     // received byte
	output logic                     rx_ready,    // byte taken
	output logic                     frame_ok,    // good frame pulse
	output logic                     frame_bad,   // rejected frame pulse
	output logic [7:0]               frame_func,  // function of last frame for us whose check passed
	output logic [15:0]              frame_check, // computed check code
	output logic                     wr_valid,    // parameter write ready
	output mfcc_pkg::mfcc_wr_s       wr_data,     // address and word
	input  wire logic                wr_ready     // store takes write
);
	typedef struct packed {
		mfcc_state_e                  st;
		logic [BUF_BYTES-1:0][7:0]    frm;
		logic [IDX_W-1:0]             n;
		logic [15:0]                  crc;
		logic [15:0]                  hist1;
		logic [15:0]                  hist2;
		logic [7:0]                   sum;
		logic [7:0]                   sum1;
		logic [2:0]                   step;
		logic                         hi_pend;
		logic [3:0]                   hi_nib;
		logic [SIL_W-1:0]             sil;
		logic                         rdy;
		mfcc_stat_s                   stat;
		logic [3:0]                   wcnt;
		logic [3:0]                   widx;
		logic [IDX_W-1:0]             dbase;
		logic [15:0]                  waddr;
		logic                         push;
		mfcc_wr_s                     wr;
	} mfcc_core_s;

	mfcc_core_s       s;
	mfcc_core_s       next_s;
	logic             take;
	logic             is_rtu;
	logic             fifo_rdy;
	logic [7:0]       last1;
	logic [7:0]       last2;
	logic [15:0]      calc_chk;
	logic [15:0]      rcv_chk;
	logic [IDX_W-1:0] plen;
	logic             chk_pass;
	logic [15:0]      wcount;
	logic             fmt06;
	logic             fmt10;
	logic [4:0]       hexv;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// ascii hex digit to {valid, nibble}; lower case is refused
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CH_0 && c <= CH_9)
			hex_val = {1'b1, c[3:0]};
		else if (c >= CH_A && c <= CH_F)
			hex_val = {1'b1, c[3:0] + 4'h9};
		else
			hex_val = 5'h00;
	endfunction

	// fresh frame accumulators
	function automatic mfcc_core_s clr(input mfcc_core_s c);
		clr = c;
		clr.crc = CRC_INIT;
		clr.hist1 = CRC_INIT;
		clr.hist2 = CRC_INIT;
		clr.sum = LRC_ZERO;
		clr.sum1 = LRC_ZERO;
		clr.n = '0;
		clr.hi_pend = 1'b0;
	endfunction

	// store one binary byte and fold it into both check codes
	function automatic mfcc_core_s fold(input mfcc_core_s c,
	                                    input logic [7:0] v,
	                                    input logic rtu);
		fold = c;
		if (c.n == IDX_W'(BUF_BYTES)) begin
			// longer than any legal frame: give up on it
			fold.st = ST_IDLE;
			fold.stat.bad = 1'b1;
		end else begin
			fold.frm[c.n[IDX_W-2:0]] = v;
			fold.n = c.n + IDX_W'(1);
			// keep history so the value before the check field survives
			fold.hist2 = c.hist1;
			fold.hist1 = c.crc;
			fold.crc = c.crc ^ {8'h00, v};
			fold.sum1 = c.sum;
			fold.sum = c.sum + v;
			fold.step = '0;
			fold.st = rtu ? ST_STEP : ST_RECV;
		end
	endfunction

	// i-th write word: big-endian data, consecutive addresses
	function automatic mfcc_wr_s word_at(input mfcc_core_s c,
	                                     input logic [3:0] i);
		logic [IDX_W-2:0] k;
		k = c.dbase[IDX_W-2:0] + {i, 1'b0};
		word_at.addr = c.waddr + {12'h000, i};
		word_at.data = {c.frm[k], c.frm[k + 5'h01]};
	endfunction

	// ------------------------------------------------------------
	// frame check evaluation
	// ------------------------------------------------------------
	assign take     = rx_valid && s.rdy;
	assign is_rtu   = (mode == MODE_RTU);
	assign hexv     = hex_val(rx_byte);
	assign last1    = s.frm[s.n[IDX_W-2:0] - 5'h01];
	assign last2    = s.frm[s.n[IDX_W-2:0] - 5'h02];
	// crc before the check field; lrc is the negated sum before it
	assign calc_chk = is_rtu ? s.hist2 : {8'h00, LRC_ZERO - s.sum1};
	assign rcv_chk  = is_rtu ? {last1, last2} : {8'h00, last1};
	assign plen     = is_rtu ? s.n - IDX_W'(2) : s.n - IDX_W'(1);
	assign chk_pass = (s.n >= (is_rtu ? IDX_W'(4) : IDX_W'(3)))
	                  && (calc_chk == rcv_chk);
	assign wcount   = {s.frm[POS_CNT_HI], s.frm[POS_CNT_LO]};
	assign fmt06    = (s.frm[POS_FUNC] == FN_WR_ONE)
	                  && (plen == IDX_W'(POS_BCNT));
	assign fmt10    = (s.frm[POS_FUNC] == FN_WR_MULTI)
	                  && (wcount != 16'h0000) && (wcount <= MAX_WORDS)
	                  && (s.frm[POS_BCNT] == {wcount[6:0], 1'b0})
	                  && ({10'h000, plen}
	                      == 16'(POS_DATA) + {wcount[14:0], 1'b0});

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.stat.ok = 1'b0;
		next_s.stat.bad = 1'b0;
		// silence timer restarts on every byte on the line
		if (rx_valid)
			next_s.sil = '0;
		else if (s.sil < SIL_W'(SILENT_CYC_P))
			next_s.sil = s.sil + SIL_W'(1);
		unique case (s.st)
			ST_IDLE: begin
				if (take && !is_rtu && rx_byte == CH_START)
					next_s.st = ST_RECV;
				else if (take && is_rtu && s.sil >= SIL_W'(SILENT_CYC_P))
					next_s = fold(next_s, rx_byte, 1'b1);
			end
			ST_RECV: begin
				if (is_rtu) begin
					if (take)
						next_s = fold(next_s, rx_byte, 1'b1);
					else if (s.sil >= SIL_W'(SILENT_CYC_P))
						next_s.st = ST_CHECK;
				end else if (take) begin
					if (rx_byte == CH_START) begin
						next_s = clr(next_s);
						next_s.st = ST_RECV;
					end else if (rx_byte == CH_CR) begin
						next_s.st = s.hi_pend ? ST_IDLE : ST_LF;
						next_s.stat.bad = s.hi_pend;
					end else if (!hexv[4]) begin
						next_s.st = ST_IDLE;
						next_s.stat.bad = 1'b1;
					end else if (s.hi_pend) begin
						next_s = fold(next_s, {s.hi_nib, hexv[3:0]}, 1'b0);
						next_s.hi_pend = 1'b0;
					end else begin
						next_s.hi_nib = hexv[3:0];
						next_s.hi_pend = 1'b1;
					end
				end
			end
			ST_STEP: begin
				// one bit step per clock keeps the datapath narrow
				next_s.crc = (s.crc >> 1) ^ (s.crc[0] ? CRC_POLY : 16'h0000);
				next_s.step = s.step + 3'h1;
				if (s.step == BIT_LAST)
					next_s.st = ST_RECV;
			end
			ST_LF: begin
				if (take) begin
					next_s.st = (rx_byte == CH_LF) ? ST_CHECK : ST_IDLE;
					next_s.stat.bad = (rx_byte != CH_LF);
				end
			end
			ST_CHECK: begin
				next_s.st = ST_IDLE;
				next_s.stat.check = calc_chk;
				if (!chk_pass) begin
					next_s.stat.bad = 1'b1;
				end else if (s.frm[POS_STATION] == my_station) begin
					next_s.stat.func = s.frm[POS_FUNC];
					if (s.frm[POS_FUNC] != FN_WR_ONE
					    && s.frm[POS_FUNC] != FN_WR_MULTI) begin
						next_s.stat.ok = 1'b1;
					end else if (fmt06 || fmt10) begin
						next_s.stat.ok = 1'b1;
						next_s.wcnt = fmt06 ? 4'h1 : wcount[3:0];
						next_s.dbase = fmt06 ? IDX_W'(POS_CNT_HI)
						                     : IDX_W'(POS_DATA);
						next_s.waddr = {s.frm[POS_ADDR_HI], s.frm[POS_ADDR_LO]};
						next_s.widx = 4'h0;
						next_s.wr = word_at(next_s, 4'h0);
						next_s.push = 1'b1;
						next_s.st = ST_DRAIN;
					end else begin
						next_s.stat.bad = 1'b1;
					end
				end
			end
			ST_DRAIN: begin
				// a full fifo holds us here and rx_ready low stalls the uart
				if (fifo_rdy) begin
					if (s.widx + 4'h1 == s.wcnt) begin
						next_s.push = 1'b0;
						next_s.st = ST_IDLE;
					end else begin
						next_s.widx = s.widx + 4'h1;
						next_s.wr = word_at(s, s.widx + 4'h1);
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.push = 1'b0;
			end
		endcase
		if (next_s.st == ST_IDLE)
			next_s = clr(next_s);
		next_s.rdy = (next_s.st == ST_IDLE) || (next_s.st == ST_RECV)
		             || (next_s.st == ST_LF);
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.crc <= CRC_INIT;
			s.hist1 <= CRC_INIT;
			s.hist2 <= CRC_INIT;
			s.rdy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// write word buffer
	// ------------------------------------------------------------
	mfcc_fifo #(
		.W ($bits(mfcc_wr_s)),
		.D (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_valid  (s.push),
		.in_data   (s.wr),
		.in_ready  (fifo_rdy),
		.out_valid (wr_valid),
		.out_data  (wr_data),
		.out_ready (wr_ready)
	);

	// registered outputs
	assign rx_ready    = s.rdy;
	assign frame_ok    = s.stat.ok;
	assign frame_bad   = s.stat.bad;
	assign frame_func  = s.stat.func;
	assign frame_check = s.stat.check;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_bit_steps;
		(s.st == ST_STEP) [*8] ##1 (s.st == ST_RECV);
	endsequence
	sequence s_rtu_take;
		s.st == ST_RECV && is_rtu && take && s.n < IDX_W'(BUF_BYTES);
	endsequence

	property p_crc_init;
		s.st == ST_IDLE |-> s.crc == CRC_INIT && s.n == '0;
	endproperty
	a_crc_init: assert property (p_crc_init)
		else $error("crc not preset at frame start");

	property p_fold;
		s_rtu_take |=> s.crc == ($past(s.crc) ^ {8'h00, $past(rx_byte)});
	endproperty
	a_fold: assert property (p_fold)
		else $error("byte not folded into crc low byte");

	property p_shift;
		s.st == ST_STEP |=> s.crc == (($past(s.crc) >> 1)
		    ^ ($past(s.crc[0]) ? CRC_POLY : 16'h0000));
	endproperty
	a_shift: assert property (p_shift)
		else $error("crc bit step wrong");

	property p_eight;
		s_rtu_take |=> s_bit_steps;
	endproperty
	a_eight: assert property (p_eight)
		else $error("not eight bit steps per byte");

	property p_rtu_end;
		s.st == ST_RECV && is_rtu && !take
		    && s.sil >= SIL_W'(SILENT_CYC_P) |=> s.st == ST_CHECK;
	endproperty
	a_rtu_end: assert property (p_rtu_end)
		else $error("silence did not end rtu frame");

	property p_rtu_nostart;
		s.st == ST_IDLE && is_rtu && take
		    && s.sil < SIL_W'(SILENT_CYC_P) |=> s.st == ST_IDLE;
	endproperty
	a_rtu_nostart: assert property (p_rtu_nostart)
		else $error("rtu frame started without silence");

	property p_ascii_start;
		s.st == ST_IDLE && !is_rtu && take && rx_byte == CH_START
		    |=> s.st == ST_RECV ##1 s.n == '0;
	endproperty
	a_ascii_start: assert property (p_ascii_start)
		else $error("colon did not open ascii frame");

	property p_crc_order;
		s.stat.ok && is_rtu |-> s.stat.check == $past(rcv_chk);
	endproperty
	a_crc_order: assert property (p_crc_order)
		else $error("crc field order mismatch");

	property p_lrc;
		s.stat.ok && !is_rtu |-> s.stat.check[7:0] + $past(s.sum1) == 8'h00;
	endproperty
	a_lrc: assert property (p_lrc)
		else $error("lrc not two's complement of sum");

	property p_discard;
		s.st == ST_CHECK && !chk_pass |=> s.st == ST_IDLE && !s.push
		    && s.stat.bad && !s.stat.ok;
	endproperty
	a_discard: assert property (p_discard)
		else $error("bad frame not discarded");

	property p_max_words;
		s.st == ST_DRAIN |-> s.wcnt != 4'h0 && {12'h000, s.wcnt} <= MAX_WORDS;
	endproperty
	a_max_words: assert property (p_max_words)
		else $error("word count out of range");

	property p_addr_step;
		s.st == ST_DRAIN && fifo_rdy && s.widx + 4'h1 != s.wcnt
		    |=> s.wr.addr == $past(s.wr.addr) + 16'h0001;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("write address not consecutive");
endmodule // mfcc_core

//--- testbench/mfcc_host_model.sv
// bus master and parameter store stand-in facing the frame check core
`timescale 1ns/1ns
module mfcc_host_model (
	input  wire logic       core_clk, // system clock
	input  wire logic       rx_ready, // core takes byte
	output logic            rx_valid, // byte offered
	output logic [7:0]      rx_byte,  // byte on the line
	input  wire logic       wr_valid, // write word waiting
	output logic            wr_ready  // store accepts word
);
	integer     seed = 32'h470B62C2;
	logic [7:0] last = 8'h00;
	int         last_wait = 0;  // edges the last byte waited for rx_ready

	initial begin
		rx_valid = 1'b0;
		rx_byte  = 8'hFF;
		wr_ready = 1'b0;
	end

	// store stalls about half the time so long writes fill the fifo
	always @(posedge core_clk) begin
		wr_ready <= 1'($random(seed));
	end

	// ------------------------------------------------------------
	// byte handshake
	// ------------------------------------------------------------
	// request held until the edge that sees rx_ready high
	task automatic send_byte(input logic [7:0] b, output bit to);
		int n;
		n        = 0;
		to       = 1'b0;
		rx_valid <= 1'b1;
		rx_byte  <= b;
		last     = b;
		@(posedge core_clk);
		while (rx_ready !== 1'b1) begin
			n++;
			if (n > 100) begin
				to = 1'b1;
				break;
			end
			@(posedge core_clk);
		end
		last_wait = n;
	endtask

	// released line shows the inverse of the last byte, not a stale copy
	task automatic idle(input int n);
		rx_valid <= 1'b0;
		rx_byte  <= ~last;
		repeat (n) @(posedge core_clk);
	endtask

	function automatic logic [7:0] hexc(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction

	// ------------------------------------------------------------
	// frame framing: f already carries its check bytes
	// ------------------------------------------------------------
	task automatic send_frame(input bit rtu, input logic [7:0] f[$],
	                          input int sil, output bit to);
		bit t;
		to = 1'b0;
		if (rtu)
			idle(sil);
		else begin
			send_byte(8'h3A, t);
			to |= t;
		end
		foreach (f[i]) begin
			if (rtu) begin
				send_byte(f[i], t);
				to |= t;
			end else begin
				send_byte(hexc(f[i][7:4]), t);
				to |= t;
				send_byte(hexc(f[i][3:0]), t);
				to |= t;
			end
		end
		if (!rtu) begin
			send_byte(8'h0D, t);
			to |= t;
			send_byte(8'h0A, t);
			to |= t;
		end
		idle(1);
	endtask
endmodule // mfcc_host_model

//--- testbench/testbench.sv
// self-checking bench for the frame check codes core
`timescale 1ns/1ns
module testbench;
	import mfcc_pkg::*;
	localparam int SIL = 50;

	logic        core_clk   = 1'b0;
	logic        rstn       = 1'b0;
	mfcc_mode_e  mode       = MODE_RTU;
	logic [7:0]  my_station = 8'h01;
	logic        rx_valid, rx_ready, frame_ok, frame_bad;
	logic        wr_valid, wr_ready;
	logic [7:0]  rx_byte, frame_func;
	logic [15:0] frame_check;
	mfcc_wr_s    wr_data;
	int          fail_count      = 0;
	int          samples_checked = 0;
	integer      seed            = 32'h470B62C2;
	int          n_ok, n_bad;
	mfcc_wr_s    got_wr[$];
	logic [7:0]  q[$];
	int          gap             = SIL + 10;

	always #4 core_clk = ~core_clk;

	mfcc_core #(.SILENT_CYC_P(SIL), .DEPTH(4)) i_mfcc_core (
		.core_clk(core_clk), .rstn(rstn), .mode(mode),
		.my_station(my_station), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.rx_ready(rx_ready), .frame_ok(frame_ok), .frame_bad(frame_bad),
		.frame_func(frame_func), .frame_check(frame_check),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready));

	mfcc_host_model i_host (
		.core_clk(core_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .wr_valid(wr_valid), .wr_ready(wr_ready));

	// pulses and taken words are gathered at each edge
	always @(posedge core_clk) begin
		if (rstn === 1'b1) begin
			if (frame_ok === 1'b1) n_ok++;
			if (frame_bad === 1'b1) n_bad++;
			if (wr_valid === 1'b1 && wr_ready === 1'b1)
				got_wr.push_back(wr_data);
		end
	end

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c[7:0] = c[7:0] ^ b[i];
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction

	function automatic logic [7:0] lrc(input logic [7:0] b[$]);
		int s;
		s = 0;
		foreach (b[i]) s = s + int'(b[i]);
		return 8'(-s);
	endfunction

	task automatic check(input string name, input logic [31:0] seen,
	                     input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// one frame: exp 0 silent, 1 accepted, 2 rejected
	// ------------------------------------------------------------
	task automatic do_frame(input bit rtu, input logic [7:0] p[$],
	                        input logic [7:0] flip, input int exp);
		logic [15:0] chk;
		logic [7:0]  f[$];
		mfcc_wr_s    w[$];
		int          nw, n;
		bit          to;
		chk = rtu ? crc16(p) : {8'h00, lrc(p)};
		f = p;
		f.push_back(chk[7:0] ^ flip);
		if (rtu) f.push_back(chk[15:8]);
		nw = (p[1] == 8'h06) ? 1 : int'({p[4], p[5]});
		if (exp == 1 && (p[1] == 8'h06 || p[1] == 8'h10))
			for (int i = 0; i < nw; i++)
				w.push_back({16'({p[2], p[3]} + i), (p[1] == 8'h06) ?
				            {p[4], p[5]} : {p[7+2*i], p[8+2*i]}});
		n_ok = 0;
		n_bad = 0;
		got_wr.delete();
		mode <= rtu ? MODE_RTU : MODE_ASCII;
		i_host.send_frame(rtu, f, gap, to);
		n = 0;
		while (n_ok + n_bad == 0 && n < SIL + 100 && !to) begin
			@(posedge core_clk);
			n++;
		end
		while (got_wr.size() < w.size() && n < 600) begin
			@(posedge core_clk);
			n++;
		end
		repeat (20) @(posedge core_clk);
		if (to || (exp != 0 && n_ok + n_bad == 0)) begin
			fail_count++;
			give_verdict();
		end
		check("ok pulses", n_ok, 32'(exp == 1));
		check("bad pulses", n_bad, 32'(exp == 2));
		if (exp != 0)
			check("check code", frame_check, chk);
		if (exp == 1)
			check("function", frame_func, p[1]);
		// a started rtu frame holds every later byte for eight bit steps
		check("byte wait", i_host.last_wait, (rtu && gap > SIL) ? 8 : 0);
		check("word count", got_wr.size(), w.size());
		foreach (w[i])
			if (i < got_wr.size()) check("write word", got_wr[i], w[i]);
	endtask

	task automatic rand_frame(input int nw, input bit rtu, input logic [7:0] st,
	                          input logic [7:0] flip, input int exp);
		logic [7:0] r[$];
		r = '{st, 8'h10, 8'($random(seed)), 8'($random(seed)), 8'h00,
		      8'(nw), 8'(2 * nw)};
		for (int i = 0; i < 2 * nw; i++) r.push_back(8'($random(seed)));
		do_frame(rtu, r, flip, exp);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		q = '{8'h01, 8'h10, 8'h01, 8'h12, 8'h00, 8'h02, 8'h04,
		      8'h0B, 8'hB8, 8'h00, 8'h00};
		check("model crc", crc16(q), 16'hEBFC);
		check("model lrc", lrc(q), 8'h13);
		do_frame(1, q, 8'h00, 1);
		do_frame(0, q, 8'h00, 1);
		do_frame(1, q, 8'h01, 2);
		do_frame(0, q, 8'h40, 2);
		q = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
		check("model crc", crc16(q), 16'hB3C5);
		do_frame(1, q, 8'h00, 1);
		do_frame(0, q, 8'h00, 1);
		// too little silence after the ascii frame: rtu bytes are swallowed
		gap = 2;
		do_frame(1, q, 8'h00, 0);
		gap = SIL + 10;
		q = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64};
		check("model lrc", lrc(q), 8'h93);
		do_frame(0, q, 8'h00, 1);
		rand_frame(11, 1, 8'h01, 8'h00, 2);
		rand_frame(10, 1, 8'h01, 8'h00, 1);
		rand_frame(3, 1, 8'h02, 8'h00, 0);
		// mid-run reset: outputs return to rest, frames resume after it
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		check("wr_valid after reset", wr_valid, 1'b0);
		check("check after reset", frame_check, 16'h0000);
		@(posedge core_clk);
		my_station <= 8'h5A;
		for (int k = 0; k < 8; k++)
			rand_frame(1 + ($unsigned($random(seed)) % 10),
			           1'($random(seed)), 8'h5A, 8'h00, 1);
		give_verdict();
	end
endmodule // testbench
